// ===== core/twi_abort_pkg.sv
/*
  constants of the two-wire controller status block: register offsets,
  field positions, values after reset and widths.
  assumes a 32-bit register port with byte offsets on aligned words.

  //Operation
  //[R1] transmit fifo fill count reads in bits 2:0, zero after reset
  //[R2] receive fifo fill count reads in bits 2:0, zero after reset
  //[R3] read bit written while answering a slave read request sets cause 15
  //[R4] slave losing bus while transmitting sets cause 14 and 12 together
  //[R5] transmitter compares data line with driven bit at clock rise
  //[R6] slave read command with filled transmit fifo sets 13, raises abort
  //[R7] master arbitration loss sets cause 12; with 14 it means slave loss
  //[R8] master and slave may run together; causes kept apart by side
  //[R9] master start while master mode disabled sets cause 11
  //[R10] ten-bit read with repeated start disallowed sets cause 10
  //[R11] start byte with repeated start disallowed sets cause 9
  //[R12] clearing 9 with cause present clears one cycle, then sets again
  //[R13] acknowledged start byte sent as master sets cause 7
  //[R14] general call followed by a read command sets cause 5
*/
package twi_abort_pkg;

  // register byte offsets
  localparam logic [7:0] TX_LEVEL_OFS    = 8'h00;
  localparam logic [7:0] RX_LEVEL_OFS    = 8'h04;
  localparam logic [7:0] ABORT_CAUSE_OFS = 8'h08;
  localparam logic [7:0] ABORT_MASK_OFS  = 8'h0c;
  localparam logic [7:0] CONFIG_OFS      = 8'h10;
  localparam logic [7:0] TARGET_OFS      = 8'h14;

  // abort cause bit positions
  localparam int SLV_RD_CONFLICT_BIT = 15;
  localparam int SLV_LOST_BUS_BIT    = 14;
  localparam int SLV_FLUSH_BIT       = 13;
  localparam int LOST_ARB_BIT        = 12;
  localparam int MST_DISABLED_BIT    = 11;
  localparam int TENBIT_NORESTART_BIT = 10;
  localparam int SBYTE_NORESTART_BIT = 9;
  localparam int SBYTE_ACKED_BIT     = 7;
  localparam int GCALL_READ_BIT      = 5;

  // configuration and target field positions
  localparam int CFG_MASTER_EN_BIT   = 0;
  localparam int CFG_RESTART_BIT     = 5;
  localparam int TAR_GC_OR_SB_BIT    = 10;
  localparam int TAR_SPECIAL_BIT     = 11;
  localparam int TAR_TENBIT_BIT      = 12;

  // widths
  localparam int LEVEL_W = 3;
  localparam int CAUSE_W = 16;
  localparam int CFG_W   = 6;
  localparam int TAR_W   = 13;

  // values after reset, fill count limit and implemented cause bits
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 3'h7;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 16'h0000;
  localparam logic [CAUSE_W-1:0] MASK_RST  = 16'h0000;
  localparam logic [CAUSE_W-1:0] CAUSE_IMPL = 16'hfea0;
  localparam logic [CFG_W-1:0]   CFG_RST   = 6'h21;
  localparam logic [TAR_W-1:0]   TAR_RST   = 13'h0000;

endpackage : twi_abort_pkg

// ===== core/twi_abort_status.sv
/*
  fifo fill counts and transmit abort cause recording of a two-wire
  controller, with register port and abort interrupt.
  assumes master and slave state machines on ref_clk give one-cycle
  pulses and levels; scl and sda come straight from the pins.
*/
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
module twi_abort_status (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // register port
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [31:0]                         reg_wr_data,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [31:0]                         reg_rd_data,
  // fifo activity
  input  wire logic                                tx_push,
  input  wire logic                                tx_pop,
  input  wire logic                                rx_push,
  input  wire logic                                rx_pop,
  // data/command writes from software
  input  wire logic                                dcmd_wr,
  input  wire logic                                dcmd_read,
  // master side
  input  wire logic                                mst_start_req,
  input  wire logic                                mst_tx_driving,
  input  wire logic                                start_byte_acked,
  // slave side
  input  wire logic                                slv_read_req,
  input  wire logic                                slv_rd_cmd,
  input  wire logic                                slv_tx_driving,
  // serial link
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  input  wire logic                                tx_bit,
  // events
  output logic                                     transmit_abort_event,
  output logic                                     irq
);
  import twi_abort_pkg::*;

  // saturating fill count update shared by both fifos
  function automatic logic [LEVEL_W-1:0] level_next(input logic [LEVEL_W-1:0] lvl,
                                                    input logic push,
                                                    input logic pop);
    logic [LEVEL_W-1:0] res;
    res = lvl;
    if (push && !pop && lvl != LEVEL_MAX) begin
      res = lvl + 3'h1;
    end else if (pop && !push && lvl != LEVEL_RST) begin
      res = lvl - 3'h1;
    end
    return res;
  endfunction : level_next

  // state
  logic [LEVEL_W-1:0] tx_level_ff;
  logic [LEVEL_W-1:0] rx_level_ff;
  logic [CAUSE_W-1:0] cause_ff;
  logic [CAUSE_W-1:0] nxt_cause;
  logic [CAUSE_W-1:0] mask_ff;
  logic [CFG_W-1:0]   cfg_ff;
  logic [TAR_W-1:0]   tar_ff;
  logic               scl_prev_ff;

  // decode and event terms
  logic               scl_s;
  logic               sda_s;
  logic               scl_rise;
  logic               bus_mismatch;
  logic               mst_lost;
  logic               slv_lost;
  logic [CAUSE_W-1:0] set_bits;
  logic [CAUSE_W-1:0] clr_bits;
  logic               restart_ok;
  logic               master_en;
  logic               sbyte_cause;
  logic               gcall_mode;

  // the pins are asynchronous, so each passes two flops first
  twi_pin_sync u_scl_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   (scl_in),
    .pin_sync (scl_s)
  );

  twi_pin_sync u_sda_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   (sda_in),
    .pin_sync (sda_s)
  );

  // previous clock line level for edge finding
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
    end
  end

  // data line checked against the driven bit at each clock rise [R5]
  assign scl_rise     = scl_s && !scl_prev_ff;
  assign bus_mismatch = scl_rise && (sda_s != tx_bit);
  // losses are attributed by side since both may be active at once [R8]
  assign mst_lost     = bus_mismatch && mst_tx_driving;
  assign slv_lost     = bus_mismatch && slv_tx_driving;

  assign restart_ok   = cfg_ff[CFG_RESTART_BIT];
  assign master_en    = cfg_ff[CFG_MASTER_EN_BIT];
  // start byte selected while repeated start is off keeps asserting [R11]
  assign sbyte_cause  = !restart_ok && tar_ff[TAR_SPECIAL_BIT] && tar_ff[TAR_GC_OR_SB_BIT];
  assign gcall_mode   = tar_ff[TAR_SPECIAL_BIT] && !tar_ff[TAR_GC_OR_SB_BIT];

  // cause set terms, one per recorded reason
  always_comb begin
    set_bits = CAUSE_RST;
    set_bits[SLV_RD_CONFLICT_BIT]  = slv_read_req && dcmd_wr && dcmd_read;     // [R3]
    set_bits[SLV_LOST_BUS_BIT]     = slv_lost;                                 // [R4]
    set_bits[SLV_FLUSH_BIT]        = slv_rd_cmd && (tx_level_ff != LEVEL_RST); // [R6]
    set_bits[LOST_ARB_BIT]         = mst_lost || slv_lost;                     // [R4] [R7]
    set_bits[MST_DISABLED_BIT]     = mst_start_req && !master_en;              // [R9]
    set_bits[TENBIT_NORESTART_BIT] = !restart_ok && tar_ff[TAR_TENBIT_BIT]
                                     && dcmd_wr && dcmd_read;                  // [R10]
    set_bits[SBYTE_NORESTART_BIT]  = sbyte_cause;                              // [R11]
    set_bits[SBYTE_ACKED_BIT]      = start_byte_acked;                         // [R13]
    set_bits[GCALL_READ_BIT]       = gcall_mode && dcmd_wr && dcmd_read;       // [R14]
  end

  // write one to clear, only on implemented bits
  assign clr_bits = (reg_wr && reg_addr == ABORT_CAUSE_OFS) ?
                    (reg_wr_data[CAUSE_W-1:0] & CAUSE_IMPL) : CAUSE_RST;

  // set wins over clear except bit 9, whose clear holds for one cycle
  always_comb begin
    nxt_cause = (cause_ff & ~clr_bits) | set_bits;
    nxt_cause[SBYTE_NORESTART_BIT] = (cause_ff[SBYTE_NORESTART_BIT]
                                      || set_bits[SBYTE_NORESTART_BIT])
                                     && !clr_bits[SBYTE_NORESTART_BIT]; // [R12]
  end

  // abort cause register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cause_ff <= CAUSE_RST;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  // abort event pulses when any cause is newly raised; flushes tx fifo [R6]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_abort_event <= 1'b0;
    end else begin
      transmit_abort_event <= |(set_bits & ~cause_ff);
    end
  end

  // fill counts; a pending abort event empties the transmit count [R1] [R2]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_level_ff <= LEVEL_RST;
      rx_level_ff <= LEVEL_RST;
    end else begin
      tx_level_ff <= transmit_abort_event ? LEVEL_RST
                                          : level_next(tx_level_ff, tx_push, tx_pop); // [R1]
      rx_level_ff <= level_next(rx_level_ff, rx_push, rx_pop);                        // [R2]
    end
  end

  // software writable control: mask, configuration and target fields
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_ff <= MASK_RST;
      cfg_ff  <= CFG_RST;
      tar_ff  <= TAR_RST;
    end else if (reg_wr) begin
      if (reg_addr == ABORT_MASK_OFS) begin
        mask_ff <= reg_wr_data[CAUSE_W-1:0] & CAUSE_IMPL;
      end
      if (reg_addr == CONFIG_OFS) begin
        cfg_ff <= reg_wr_data[CFG_W-1:0];
      end
      if (reg_addr == TARGET_OFS) begin
        tar_ff <= reg_wr_data[TAR_W-1:0];
      end
    end
  end

  // level interrupt, one cycle behind the cause register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(cause_ff & mask_ff);
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rd_data <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        TX_LEVEL_OFS:    reg_rd_data <= {29'h0, tx_level_ff};   // [R1]
        RX_LEVEL_OFS:    reg_rd_data <= {29'h0, rx_level_ff};   // [R2]
        ABORT_CAUSE_OFS: reg_rd_data <= {16'h0, cause_ff};
        ABORT_MASK_OFS:  reg_rd_data <= {16'h0, mask_ff};
        CONFIG_OFS:      reg_rd_data <= {26'h0, cfg_ff};
        TARGET_OFS:      reg_rd_data <= {19'h0, tar_ff};
        default:         reg_rd_data <= 32'h0000_0000;
      endcase
    end else begin
      reg_rd_data <= 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_tx_level_read: assert property ( // [R1]
    reg_rd && reg_addr == TX_LEVEL_OFS |=> reg_rd_data == {29'h0, $past(tx_level_ff)})
    else $error("transmit fill count read mismatch");

  chk_rx_level_step: assert property ( // [R2]
    rx_push && !rx_pop && rx_level_ff != LEVEL_MAX |=> rx_level_ff == $past(rx_level_ff) + 3'h1)
    else $error("receive fill count did not step up");

  chk_slv_conflict: assert property ( // [R3]
    slv_read_req && dcmd_wr && dcmd_read |=> cause_ff[SLV_RD_CONFLICT_BIT])
    else $error("slave read conflict not recorded");

  chk_slave_loss_pair: assert property ( // [R4]
    slv_lost |=> cause_ff[SLV_LOST_BUS_BIT] && cause_ff[LOST_ARB_BIT])
    else $error("slave bus loss did not set both cause bits");

  chk_mismatch_edge: assert property ( // [R5]
    mst_tx_driving && $rose(scl_s) && sda_s != tx_bit |=> cause_ff[LOST_ARB_BIT])
    else $error("data line mismatch at clock rise not caught");

  chk_flush_event: assert property ( // [R6]
    slv_rd_cmd && tx_level_ff != LEVEL_RST && !cause_ff[SLV_FLUSH_BIT]
    |=> transmit_abort_event ##1 tx_level_ff == LEVEL_RST)
    else $error("stale transmit data not flushed");

  chk_master_loss_side: assert property ( // [R7]
    mst_lost && !slv_lost && !cause_ff[SLV_LOST_BUS_BIT]
    |=> cause_ff[LOST_ARB_BIT] && !cause_ff[SLV_LOST_BUS_BIT])
    else $error("master arbitration loss marked as slave side");

  chk_sides_apart: assert property ( // [R8]
    !slv_tx_driving && !slv_lost && !cause_ff[SLV_LOST_BUS_BIT] && !clr_bits[SLV_LOST_BUS_BIT]
    |=> !cause_ff[SLV_LOST_BUS_BIT])
    else $error("slave cause raised without slave activity");

  chk_master_disabled: assert property ( // [R9]
    mst_start_req && !cfg_ff[CFG_MASTER_EN_BIT] |=> cause_ff[MST_DISABLED_BIT])
    else $error("start with master disabled not recorded");

  chk_tenbit_read: assert property ( // [R10]
    dcmd_wr && dcmd_read && tar_ff[TAR_TENBIT_BIT] && !cfg_ff[CFG_RESTART_BIT]
    |=> cause_ff[TENBIT_NORESTART_BIT])
    else $error("ten-bit read without repeated start not recorded");

  chk_sbyte_norestart: assert property ( // [R11]
    !cfg_ff[CFG_RESTART_BIT] && tar_ff[TAR_SPECIAL_BIT] && tar_ff[TAR_GC_OR_SB_BIT]
    && !clr_bits[SBYTE_NORESTART_BIT] |=> cause_ff[SBYTE_NORESTART_BIT])
    else $error("start byte without repeated start not recorded");

  chk_sbyte_reassert: assert property ( // [R12]
    clr_bits[SBYTE_NORESTART_BIT] && sbyte_cause && !reg_wr_data[CFG_RESTART_BIT]
    |=> !cause_ff[SBYTE_NORESTART_BIT] ##1 (cause_ff[SBYTE_NORESTART_BIT] || !$past(sbyte_cause)))
    else $error("bit 9 did not clear for one cycle then return");

  chk_sbyte_acked: assert property ( // [R13]
    start_byte_acked |=> cause_ff[SBYTE_ACKED_BIT])
    else $error("acknowledged start byte not recorded");

  chk_gcall_read: assert property ( // [R14]
    gcall_mode && dcmd_wr && dcmd_read |=> cause_ff[GCALL_READ_BIT])
    else $error("general call read not recorded");

  chk_irq_follows: assert property (
    |(cause_ff & mask_ff) |=> irq)
    else $error("interrupt not raised for unmasked cause");

endmodule : twi_abort_status

// ===== core/twi_pin_sync.sv
/*
  two flip-flop synchroniser for one pin level.
  assumes the pin is asynchronous to ref_clk; only the second stage is
  read by anything outside.
*/
`timescale 1ns/100ps
module twi_pin_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      pin_sync
);

  logic meta_ff;

  // first stage feeds only the second; reset to idle bus level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_ff  <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      meta_ff  <= pin_in;
      pin_sync <= meta_ff;
    end
  end

endmodule : twi_pin_sync

// ===== tb/twi_abort_status_test.sv
/*
  self-checking bench of the abort cause and fifo level block.
  assumes the design package, the design and the remote bus model.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module twi_abort_status_test;
  import twi_abort_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, tx_push, tx_pop, rx_push, rx_pop;
  logic        dcmd_wr, dcmd_read, mst_start_req, mst_tx_driving, start_byte_acked;
  logic        slv_read_req, slv_rd_cmd, slv_tx_driving, tx_bit;
  logic        transmit_abort_event, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data, x;
  wire         scl_in, sda_in;
  int          bad_count, tests_run, ev_cnt, exp_ev, mtx, mrx;
  logic [15:0] mcause, mmask;
  logic [5:0]  mcfg;
  logic [12:0] mtar;

  twi_abort_status uut (.ref_clk, .rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
    .reg_rd_data, .tx_push, .tx_pop, .rx_push, .rx_pop, .dcmd_wr, .dcmd_read,
    .mst_start_req, .mst_tx_driving, .start_byte_acked, .slv_read_req, .slv_rd_cmd,
    .slv_tx_driving, .scl_in, .sda_in, .tx_bit, .transmit_abort_event, .irq);
  twi_remote_dev remote (.scl(scl_in), .sda(sda_in));

  // clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // event pulses counted mid-cycle, away from the launching edge
  always @(negedge ref_clk) if (transmit_abort_event === 1'b1) ev_cnt++;

  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic int sat(input int v);
    return (v > 7) ? 7 : ((v < 0) ? 0 : v);
  endfunction : sat

  // reference register view of the model
  function automatic logic [31:0] expv(input logic [7:0] a);
    case (a)
      TX_LEVEL_OFS:    return 32'(mtx);
      RX_LEVEL_OFS:    return 32'(mrx);
      ABORT_CAUSE_OFS: return {16'h0000, mcause};
      ABORT_MASK_OFS:  return {16'h0000, mmask};
      CONFIG_OFS:      return {26'h0, mcfg};
      TARGET_OFS:      return {19'h0, mtar};
      default:         return 32'h0000_0000;
    endcase
  endfunction : expv

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // a newly raised cause pulses the event and flushes the transmit fifo
  task automatic set_cause(input logic [15:0] b);
    if ((b & ~mcause) != 16'h0000) begin
      exp_ev++;
      mtx = 0;
    end
    mcause |= b;
  endtask : set_cause

  task automatic wait_ev();
    for (int i = 0; i < 60 && ev_cnt != exp_ev; i++) @(posedge ref_clk);
    `CHK(ev_cnt, exp_ev)
    if (ev_cnt != exp_ev) print_verdict();
  endtask : wait_ev

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    case (a)
      ABORT_CAUSE_OFS: mcause &= ~d[15:0];
      ABORT_MASK_OFS:  mmask = d[15:0] & CAUSE_IMPL;
      CONFIG_OFS:      mcfg = d[5:0];
      TARGET_OFS:      mtar = d[12:0];
      default:         ;
    endcase
  endtask : wr

  // read strobe for one cycle, data looked at in the following cycle only
  task automatic rchk(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rd_data, expv(a))
    `CHK(irq, ((mcause & mmask) != 16'h0000))
  endtask : rchk

  // one-cycle pulse on a selected event input
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: tx_push <= 1'b1;
      2: rx_push <= 1'b1;
      4: dcmd_wr <= 1'b1;
      5: mst_start_req <= 1'b1;
      6: start_byte_acked <= 1'b1;
      default: slv_rd_cmd <= 1'b1;
    endcase
    @(posedge ref_clk);
    {tx_push, rx_push, dcmd_wr, mst_start_req, start_byte_acked, slv_rd_cmd} <= '0;
  endtask : pulse

  // main sequence
  initial begin
    {reg_wr, reg_rd, tx_push, tx_pop, rx_push, rx_pop, dcmd_wr, dcmd_read} = '0;
    {mst_start_req, mst_tx_driving, start_byte_acked, slv_read_req} = '0;
    {slv_rd_cmd, slv_tx_driving, tx_bit, reg_addr, reg_wr_data} = '0;
    {bad_count, tests_run, ev_cnt, exp_ev, mtx, mrx} = '0;
    {mcause, mmask, mtar} = '0;
    mcfg = CFG_RST;
    x = 32'h0000_000d;
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rchk(8'(a));
    repeat (9) begin
      pulse(0);
      pulse(2);
      mtx = sat(mtx + 1);
      mrx = sat(mrx + 1);
    end
    rchk(TX_LEVEL_OFS);
    rchk(RX_LEVEL_OFS);
    // random push and pop traffic on both fifos
    repeat (80) begin
      xs();
      @(posedge ref_clk);
      {rx_pop, rx_push, tx_pop, tx_push} <= x[3:0];
      mtx = sat(mtx + int'(x[0]) - int'(x[1]));
      mrx = sat(mrx + int'(x[2]) - int'(x[3]));
    end
    @(posedge ref_clk);
    {rx_pop, rx_push, tx_pop, tx_push} <= 4'h0;
    wr(TX_LEVEL_OFS, 32'h0000_0005);
    rchk(TX_LEVEL_OFS);
    rchk(RX_LEVEL_OFS);
    wr(ABORT_MASK_OFS, 32'h0000_ffff);
    rchk(ABORT_MASK_OFS);
    // stale transmit data flushed on a slave read command
    pulse(0);
    mtx = sat(mtx + 1);
    pulse(7);
    set_cause(16'h2000);
    wait_ev();
    rchk(TX_LEVEL_OFS);
    wr(ABORT_CAUSE_OFS, 32'h0000_ffff);
    pulse(7);
    rchk(ABORT_CAUSE_OFS);
    // read bit written while answering a remote read, then causes 11, 10, 5 and 7
    @(posedge ref_clk);
    slv_read_req <= 1'b1;
    dcmd_read <= 1'b1;
    pulse(4);
    set_cause(16'h8000);
    wait_ev();
    slv_read_req <= 1'b0;
    wr(CONFIG_OFS, 32'h0000_0020);
    pulse(5);
    set_cause(16'h0800);
    wait_ev();
    wr(CONFIG_OFS, 32'h0000_0001);
    wr(TARGET_OFS, 32'h0000_1000);
    pulse(4);
    set_cause(16'h0400);
    wait_ev();
    wr(CONFIG_OFS, 32'h0000_0021);
    wr(TARGET_OFS, 32'h0000_0800);
    pulse(4);
    set_cause(16'h0020);
    wait_ev();
    pulse(6);
    set_cause(16'h0080);
    wait_ev();
    rchk(ABORT_CAUSE_OFS);
    // start byte with repeated start disallowed is a level cause
    wr(TARGET_OFS, 32'h0000_0c00);
    wr(CONFIG_OFS, 32'h0000_0001);
    set_cause(16'h0200);
    wait_ev();
    wr(ABORT_CAUSE_OFS, 32'h0000_0200);
    set_cause(16'h0200);
    wait_ev();
    rchk(ABORT_CAUSE_OFS);
    wr(TARGET_OFS, 32'h0000_0000);
    wr(ABORT_CAUSE_OFS, 32'h0000_0200);
    rchk(ABORT_CAUSE_OFS);
    // data line compared against the driven bit, master then slave
    wr(CONFIG_OFS, 32'h0000_0021);
    wr(ABORT_CAUSE_OFS, 32'h0000_ffff);
    @(posedge ref_clk);
    tx_bit <= 1'b1;
    mst_tx_driving <= 1'b1;
    remote.send_bit(1'b1);
    repeat (8) @(posedge ref_clk);
    rchk(ABORT_CAUSE_OFS);
    remote.send_bit(1'b0);
    set_cause(16'h1000);
    wait_ev();
    @(posedge ref_clk);
    mst_tx_driving <= 1'b0;
    wr(ABORT_CAUSE_OFS, 32'h0000_1000);
    slv_tx_driving <= 1'b1;
    remote.send_bit(1'b0);
    set_cause(16'h5000);
    wait_ev();
    @(posedge ref_clk);
    slv_tx_driving <= 1'b0;
    rchk(ABORT_CAUSE_OFS);
    // interrupt masked off, then causes cleared with the mask back on
    wr(ABORT_MASK_OFS, 32'h0000_0000);
    rchk(ABORT_CAUSE_OFS);
    wr(ABORT_MASK_OFS, 32'h0000_ffff);
    wr(ABORT_CAUSE_OFS, 32'h0000_ffff);
    rchk(ABORT_CAUSE_OFS);
    `CHK(ev_cnt, exp_ev)
    print_verdict();
  end

  // hang guard, far beyond the normal run length
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule : twi_abort_status_test

// ===== tb/twi_remote_dev.sv
/*
  behavioural remote party on the two-wire bus, clocking single bits.
  assumes pull-ups on both lines; its 125 ns bit clock runs only in frames.
*/
`timescale 1ns/100ps
module twi_remote_dev (
  // bus lines as seen at the pins
  output logic scl,
  output logic sda
);
  // idle: both lines released, so the pull-ups hold them high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // data changes only while scl is low, then scl rises mid-bit
  task automatic send_bit(input logic v);
    // start off the sampling edge so the synchroniser never races the pin
    #2.0 scl = 1'b0;
    #31.0 sda = v;
    #31.5 scl = 1'b1;
    #62.5 scl = 1'b0;
    #20.0 sda = 1'b1; // released, pull-up wins
    #20.0 scl = 1'b1;
  endtask : send_bit
endmodule : twi_remote_dev
